//--- ddly_sync.v
// Purpose: Qualified sync sequencer with per-group digital delay release
// Assumes: Distribution clock is clk_sys_in; output clocks arrive as inputs
// Notes: Group run outputs are gate enables for the dividers, high = running
`timescale 1ns/1ps
`include "ddly_sync_map.vh"
module ddly_sync (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire sync_pin_in,
    input wire [`NUM_GROUPS-1:0] out_clk_in,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [`NUM_GROUPS-1:0] grp_run_out,
    output reg [`NUM_GROUPS-1:0] grp_half_step_out,
    output reg sync_busy_out
);
    localparam ST_IDLE = 3'h0;
    localparam ST_HOLD = 3'h1;
    localparam ST_QUAL = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_PULSE = 3'h4;
    localparam ST_REL = 3'h5;
    // Release count runs from the forced-low edge; the zero-delay rise is this far behind it
    localparam [3:0] REL_LEAD = `PULSE_WIDTH + `PULSE_TO_RISE - `PULSE_TO_LOW;

    reg [`DDLY_W-1:0] ddly_r [0:`NUM_GROUPS-1];
    reg [`DDLY_W-1:0] ddly_act_r [0:`NUM_GROUPS-1];
    reg [`NUM_GROUPS-1:0] hs_r;
    reg [`NUM_GROUPS-1:0] exempt_r;
    reg [31:0] ctrl_r;
    reg [2:0] pin_s1_r, pin_s2_r, pin_s3_r;
    reg pin_r;
    reg [`NUM_GROUPS-1:0] q1_r, q2_r, q3_r;
    reg [`NUM_GROUPS-1:0] qclk_r;
    reg qclk_d_r;
    reg pol_d_r;
    reg [2:0] st_r;
    reg [3:0] cnt_r;
    reg [`DDLY_W+3:0] rel_cnt_r;
    reg auto_req_r;
    reg req_lat_r;
    reg [31:0] awaddr_r;
    reg [31:0] wdata_r;
    reg aw_have_r, w_have_r;

    wire req_level = pin_r ^ ctrl_r[`CF_POL_INV];
    wire [`GRP_IDX_W-1:0] qsel = ctrl_r[`CF_QSEL_MSB:`CF_QSEL_LSB];
    wire qsel_ok = (qsel < `NUM_GROUPS);
    wire qclk_fall = qsel_ok && qclk_d_r && !qclk_r[qsel];
    wire qexempt = qsel_ok && exempt_r[qsel];
    wire pol_toggle = pol_d_r != ctrl_r[`CF_POL_INV];
    wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    wire [7:0] wofs = awaddr_r[7:0];
    wire wr_grp = wr_go && (wofs <= `OFS_GRP5) && (wofs[1:0] == 2'h0);
    wire [`GRP_IDX_W-1:0] widx = wofs[4:2];
    wire [`NUM_GROUPS-1:0] sync_grp = ~exempt_r;
    wire new_req = req_level | pol_toggle | auto_req_r | req_lat_r;
    wire [`NUM_GROUPS-1:0] rise_hit;

    // Pin synchroniser: change taken when stages two and three agree
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_s3_r <= 3'h0;
            pin_r <= 1'b0;
            q1_r <= {`NUM_GROUPS{1'b0}};
            q2_r <= {`NUM_GROUPS{1'b0}};
            q3_r <= {`NUM_GROUPS{1'b0}};
            qclk_r <= {`NUM_GROUPS{1'b0}};
            qclk_d_r <= 1'b0;
            pol_d_r <= 1'b0;
        end else begin
            pin_s1_r <= {2'h0, sync_pin_in};
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r[0] == pin_s3_r[0])
                pin_r <= pin_s3_r[0];
            q1_r <= out_clk_in;
            q2_r <= q1_r;
            q3_r <= q2_r;
            qclk_r <= (q2_r & q3_r) | (qclk_r & (q2_r | q3_r));
            qclk_d_r <= qsel_ok ? qclk_r[qsel] : 1'b0;
            pol_d_r <= ctrl_r[`CF_POL_INV];
        end
    end

    // AXI4-Lite write side; address and data may arrive in either order
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 32'h00000000;
            wdata_r <= 32'h00000000;
            ctrl_r <= `CTRL_RST;
            hs_r <= {`NUM_GROUPS{1'b0}};
            exempt_r <= {`NUM_GROUPS{1'b0}};
            auto_req_r <= 1'b0;
        end else begin
            auto_req_r <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_r <= s_axi_wdata;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (wr_grp) begin
                    hs_r[widx] <= wdata_r[`GF_HS];
                    exempt_r[widx] <= wdata_r[`GF_EXEMPT];
                    auto_req_r <= ctrl_r[`CF_AUTO];
                end else if (wofs == `OFS_CTRL) begin
                    ctrl_r <= wdata_r & 32'h00000077;
                end else if (wofs != `OFS_STAT) begin
                    s_axi_bresp <= 2'h2;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Pending delay counts, and the counts in force since the last sync
    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g = g + 1) begin : grp
            // A stopped group restarts once the count reaches its own delay plus REL_LEAD
            assign rise_hit[g] = !grp_run_out[g] &&
                (rel_cnt_r == {4'h0, ddly_act_r[g]} + {10'h000, REL_LEAD});
            always @(posedge clk_sys_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    ddly_r[g] <= `DDLY_RST;
                    ddly_act_r[g] <= `DDLY_RST;
                end else begin
                    if (wr_grp && widx == g)
                        ddly_r[g] <= wdata_r[`GF_DDLY_MSB:`GF_DDLY_LSB];
                    if (st_r == ST_PULSE && cnt_r == 4'h0 && sync_grp[g])
                        ddly_act_r[g] <= ddly_r[g];
                end
            end
        end
    endgenerate

    // AXI4-Lite read side
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
            if (s_axi_araddr[7:0] <= `OFS_GRP5 && s_axi_araddr[1:0] == 2'h0)
                s_axi_rdata <= {14'h0000, exempt_r[s_axi_araddr[4:2]],
                                hs_r[s_axi_araddr[4:2]], 6'h00, ddly_r[s_axi_araddr[4:2]]};
            else if (s_axi_araddr[7:0] == `OFS_CTRL)
                s_axi_rdata <= ctrl_r;
            else if (s_axi_araddr[7:0] == `OFS_STAT)
                s_axi_rdata <= {24'h000000, 2'h0, &grp_run_out,
                                st_r, req_level, sync_busy_out};
            else
                s_axi_rresp <= 2'h2;
        end
    end

    // Sync sequencer; an unqualified sync skips the edge wait
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            rel_cnt_r <= {(`DDLY_W+4){1'b0}};
            req_lat_r <= 1'b0;
            grp_run_out <= {`NUM_GROUPS{1'b1}};
            grp_half_step_out <= {`NUM_GROUPS{1'b0}};
            sync_busy_out <= 1'b0;
        end else begin
            grp_half_step_out <= hs_r;
            sync_busy_out <= (st_r != ST_IDLE);
            // Polarity-toggle and auto requests met while busy wait here instead of being dropped
            req_lat_r <= (st_r != ST_IDLE) & (pol_toggle | auto_req_r | req_lat_r);
            if (req_level)
                grp_run_out <= grp_run_out & exempt_r;
            case (st_r)
                ST_IDLE: begin
                    if (new_req)
                        st_r <= ST_HOLD;
                end
                ST_HOLD: begin
                    if (!req_level)
                        st_r <= ctrl_r[`CF_QUAL_EN] ? ST_QUAL : ST_WAIT;
                    cnt_r <= `QUAL_TO_PULSE - 4'h1;
                end
                ST_QUAL: begin
                    // No clock behind an out-of-range select, so do not hang
                    if (qclk_fall || !qsel_ok)
                        st_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (cnt_r == 4'h0) begin
                        st_r <= ST_PULSE;
                        cnt_r <= `PULSE_TO_LOW - 4'h1;
                    end else
                        cnt_r <= cnt_r - 4'h1;
                end
                ST_PULSE: begin
                    if (cnt_r == 4'h0) begin
                        grp_run_out <= grp_run_out & exempt_r;
                        st_r <= ST_REL;
                        // Starts at one so a match lands on the release edge
                        rel_cnt_r <= {{(`DDLY_W+3){1'b0}}, 1'b1};
                    end else
                        cnt_r <= cnt_r - 4'h1;
                end
                ST_REL: begin
                    rel_cnt_r <= rel_cnt_r + 1'b1;
                    if (req_level) begin
                        // An active pin request restarts the whole sequence
                        st_r <= ST_HOLD;
                    end else begin
                        grp_run_out <= grp_run_out | rise_hit;
                        if (&(grp_run_out | rise_hit))
                            st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule

//--- ddly_sync_map.vh
// Purpose: Constants for the qualified dynamic digital delay sync block
// Assumes: All counts are cycles of the distribution path clock
// Notes: Register offsets are byte addresses on an AXI4-Lite slave
`ifndef DDLY_SYNC_MAP_VH
`define DDLY_SYNC_MAP_VH
`define NUM_GROUPS 6
`define GRP_IDX_W 3
`define DDLY_W 10
`define DDLY_RST 10'h005
// Register byte offsets: group config at 0x00..0x14, then control/status
`define OFS_GRP0 8'h00
`define OFS_GRP5 8'h14
`define OFS_CTRL 8'h18
`define OFS_STAT 8'h1C
// Group config fields
`define GF_DDLY_LSB 0
`define GF_DDLY_MSB 9
`define GF_HS 16
`define GF_EXEMPT 17
// Control fields
`define CF_QUAL_EN 0
`define CF_AUTO 1
`define CF_POL_INV 2
`define CF_QSEL_LSB 4
`define CF_QSEL_MSB 6
// Timing counts in distribution cycles
`define QUAL_TO_PULSE 4'h3
`define PULSE_WIDTH 4'h3
`define PULSE_TO_LOW 4'h5
`define PULSE_TO_RISE 4'h5
`define CTRL_RST 32'h00000000
`endif

//--- out_clk_model.sv
// Purpose: Output clock source that feeds the qualifier inputs
// Assumes: Every group divides by four
// Notes: A stopped or frozen group sits low, as a gated divider would
`timescale 1ns/1ps
module out_clk_model (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire [5:0] run_in,
    input wire [5:0] freeze_in,
    output logic [5:0] clk_out
);
    logic [1:0] cnt_r;
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            cnt_r <= 2'h0;
        else
            cnt_r <= cnt_r + 2'h1;
    end
    // Freeze only when a scenario asks for a stalled qualifier
    assign clk_out = run_in & ~freeze_in & {6{cnt_r[1]}};
endmodule

//--- ddly_sync_props.sv
// Purpose: Port checks for the qualified sync block
// Assumes: Full-word writes only
// Notes: Half-step, exempt, auto and polarity fields are shadowed from bus traffic
`timescale 1ns/1ps
`include "ddly_sync_map.vh"
module ddly_sync_props (
    input wire clk_sys_in,
    input wire resetn_in,
    input wire sync_pin_in,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [`NUM_GROUPS-1:0] grp_run_out,
    input wire [`NUM_GROUPS-1:0] grp_half_step_out,
    input wire sync_busy_out
);
    reg [7:0] a_r;
    reg [31:0] d_r;
    reg ag_r, dg_r, auto_r, pol_r;
    reg [5:0] hs_r, ex_r;
    wire ah = s_axi_awvalid & s_axi_awready;
    wire dh = s_axi_wvalid & s_axi_wready;
    // Halves may land in either order
    wire cm = (ah | ag_r) & (dh | dg_r);
    wire [7:0] ca = ah ? s_axi_awaddr[7:0] : a_r;
    wire [31:0] cd = dh ? s_axi_wdata : d_r;
    wire gw = cm & (ca < `OFS_CTRL);
    always @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            {a_r, d_r, ag_r, dg_r, auto_r, pol_r, hs_r, ex_r} <= '0;
        end else begin
            ag_r <= (ag_r | ah) & ~cm;
            dg_r <= (dg_r | dh) & ~cm;
            if (ah) a_r <= s_axi_awaddr[7:0];
            if (dh) d_r <= s_axi_wdata;
            if (gw) hs_r[ca[4:2]] <= cd[`GF_HS];
            if (gw) ex_r[ca[4:2]] <= cd[`GF_EXEMPT];
            if (cm && ca == `OFS_CTRL) auto_r <= cd[`CF_AUTO];
            if (cm && ca == `OFS_CTRL) pol_r <= cd[`CF_POL_INV];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    sequence s_quiet_write;
        gw && !auto_r && !sync_busy_out && !sync_pin_in;
    endsequence
    // Pin active long enough to pass the synchroniser and the hold
    sequence s_pin_held;
        (sync_pin_in ^ pol_r)[*6];
    endsequence
    chk_pin_hold: assert property (s_pin_held |-> (grp_run_out & ~ex_r) == 6'h00)
        else $error("held group still running");
    chk_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_wr_lat: assert property (cm |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_rst_run: assert property ($rose(resetn_in) |-> &grp_run_out)
        else $error("groups not running after reset");
    chk_hs_now: assert property ($stable(hs_r)[*3] |-> grp_half_step_out == hs_r)
        else $error("half step not applied");
    chk_exempt_run: assert property ($stable(ex_r)[*2] |-> &(grp_run_out | ~ex_r))
        else $error("exempt group stopped");
    chk_ddly_wait: assert property (s_quiet_write |=> $stable(grp_run_out)[*4])
        else $error("delay write moved outputs");
endmodule
bind ddly_sync ddly_sync_props u_props (.*);

//--- tb.sv
// Purpose: Register-driven and sync-pin-driven scenarios for the qualified sync block
// Assumes: Design answers every bus request within 50 cycles
// Notes: Rise times are compared between groups, not absolute
`timescale 1ns/1ps
`include "ddly_sync_map.vh"
module tb;
    logic clk_sys_in, resetn_in, sync_pin_in;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, q;
    logic [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sync_busy_out;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [5:0] out_clk_in, grp_run_out, grp_half_step_out;
    logic [5:0] freeze, fl;
    logic [1:0] rsp;
    int error_cnt, n_checks, rs[6];
    ddly_sync u_dut (.*);
    out_clk_model u_clk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
        .run_in(grp_run_out), .freeze_in(freeze), .clk_out(out_clk_in));
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    task end_sim;
        $display("Checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task ck(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: got %0h expected %0h", $time, g, e);
        end
    endtask
    // Each valid stands until the rising edge that sees its ready high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk_sys_in);
        s_axi_awaddr <= {24'h0, a};
        s_axi_araddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        for (t = 0; t < 50; t++) begin
            @(posedge clk_sys_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
            if (s_axi_rready && s_axi_rvalid) begin
                q = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
        if (t == 50) begin
            error_cnt++;
            $display("Error %0t: bus timeout", $time);
            end_sim;
        end
    endtask
    task obs(input int n);
        fl = 6'h0;
        rs = '{default: 0};
        for (int k = 1; k <= n; k++) begin
            @(negedge clk_sys_in);
            for (int g = 0; g < 6; g++) begin
                if (!grp_run_out[g]) fl[g] = 1'b1;
                else if (fl[g] && rs[g] == 0) rs[g] = k;
            end
        end
    endtask
    initial begin
        {resetn_in, sync_pin_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {freeze, error_cnt, n_checks} = '0;
        s_axi_wstrb = 4'hF;
        repeat (10) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        xfer(1'b0, `OFS_GRP0, 32'h0);
        ck(q, {22'h0, `DDLY_RST});
        xfer(1'b0, `OFS_CTRL, 32'h0);
        ck(q, `CTRL_RST);
        xfer(1'b0, 8'h40, 32'h0);
        ck({30'h0, rsp}, 32'h2);
        xfer(1'b1, 8'h08, 32'h10005);
        ck({30'h0, rsp}, 32'h0);
        repeat (3) @(posedge clk_sys_in);
        ck({26'h0, grp_half_step_out}, 32'h4);
        $display("Test 1 done");
        xfer(1'b1, `OFS_CTRL, 32'h1);
        xfer(1'b1, 8'h04, 32'h8);
        obs(150);
        ck({26'h0, fl}, 32'h0);
        $display("Test 2 done");
        // Delays stay below 13 so auto sync needs no special sequence
        xfer(1'b1, 8'h00, 32'h20005);
        xfer(1'b1, 8'h10, 32'h20005);
        xfer(1'b1, 8'h08, 32'h5);
        // Qualified auto sync; qualifier on group 4, exempt so its clock keeps running
        xfer(1'b1, `OFS_CTRL, 32'h43);
        xfer(1'b1, 8'h04, 32'h8);
        obs(300);
        ck({26'h0, fl}, 32'h2E);
        ck(rs[1] - rs[2], 32'h3);
        ck(rs[3] - rs[2], 32'h0);
        $display("Test 3 done");
        // Qualifier moves to group 2; auto sync stays on, so the delay write starts a sync
        xfer(1'b1, `OFS_CTRL, 32'h23);
        xfer(1'b1, 8'h0C, 32'h6);
        obs(300);
        ck({26'h0, fl}, 32'h2E);
        ck(rs[3] - rs[2], 32'h1);
        $display("Test 4 done");
        @(posedge clk_sys_in);
        freeze <= 6'h20;
        xfer(1'b1, `OFS_CTRL, 32'h53);
        xfer(1'b1, 8'h0C, 32'h7);
        obs(100);
        ck({26'h0, fl}, 32'h0);
        ck({31'h0, sync_busy_out}, 32'h1);
        @(posedge clk_sys_in);
        freeze <= 6'h0;
        obs(200);
        ck({26'h0, fl}, 32'h2E);
        $display("Test 5 done");
        xfer(1'b1, `OFS_CTRL, 32'h0);
        @(posedge clk_sys_in);
        sync_pin_in <= 1'b1;
        obs(60);
        ck({26'h0, fl}, 32'h2E);
        ck(rs[1], 32'h0);
        @(posedge clk_sys_in);
        sync_pin_in <= 1'b0;
        obs(200);
        ck({31'h0, rs[1] != 0}, 32'h1);
        xfer(1'b0, `OFS_STAT, 32'h0);
        ck(q, 32'h20);
        $display("Test 6 done");
        end_sim;
    end
endmodule
